// [verilog/bridge_map.svh]
`ifndef BRIDGE_MAP_SVH
`define BRIDGE_MAP_SVH
// Behaviour
// - Link indicator lit only while network link up
// - Network RX/TX indicators follow network message activity
// - Bridge port RX/TX indicators follow its traffic
// - Auxiliary port RX/TX indicators follow its traffic
// - Run indicator blinks fast normally, slow during setup
// - Accepted network packets reappear on bridge serial port, except station 255 ones with virtual server on
// - Client mode: serial packets go to network only on map hit
// - Server mode forwards decoded network commands to serial
// - Server mode returns serial reply to requesting host
// - Pending commands queued, next after previous reply
// - Client mode sends remote-station serial commands to network
// - Client mode returns matching network reply on serial
// - Mapped station substituted, checksum recomputed, then sent
// - Reply gets original station and checksum before output
// - Client mode discards unsolicited network messages
// - Virtual server answers commands for station 255
// - Virtual station exposes only registers 0 to 1999
// - Virtual commands served alike from serial or network in client mode; server mode serves only network ones
// - Virtual server is client option, routing still works
// - At most eight network connections in server mode
// - Network commands accepted only from permitted hosts

// Message store
`define MSG_BYTES 32
`define LEN_W 6
`define MSG_FULL 6'h20
`define Q_SLOTS 4
`define Q_PTR_W 2
`define Q_FULL 3'h4
`define CONN_W 3
`define MAP_ENTRIES 18
`define MAP_IDX_W 5
// Virtual station
`define VIRT_STATION 8'hff
`define VREG_WORDS 16'h07d0
`define VREG_AW 11
`define OP_READ 8'h52
`define OP_WRITE 8'h57
`define ST_OK 8'h00
`define ST_BAD 8'h01
`define VIRT_CMD_LEN 6'h07
`define VIRT_REPLY_LEN 6'h06
// Register map, byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PERMIT_LO 8'h08
`define REG_PERMIT_HI 8'h0c
`define REG_MAP_BASE 8'h40
`define REG_MAP_END 8'h88
`define CTRL_MASK 32'h0000_0007
`define CTRL_CLIENT 0
`define CTRL_VIRT 1
`define CTRL_SETUP 2
`define MAP_LOCAL_LSB 0
`define MAP_REMOTE_LSB 8
`define MAP_CONN_LSB 16
`define MAP_VALID 31
`define PERMIT_HI_RST 32'hffff_ffff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// Timing
`define CLK_HZ 20000000
`define RUN_FAST_HALF_MS 50
`define RUN_SLOW_HALF_MS 250
`define REPLY_WAIT_MS 500
`endif

// [verilog/bridge_pkg.sv]
`default_nettype none
`include "bridge_map.svh"

package bridge_pkg;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_SER_RX = 5'h02,
        S_SER_TX = 5'h04,
        S_NET_TX = 5'h08,
        S_VIRT = 5'h10
    } state_t;

    typedef logic [`MSG_BYTES-1:0][7:0] msg_t;

    typedef struct packed {
        msg_t msg;
        logic [`LEN_W-1:0] len;
        logic [`CONN_W-1:0] conn;
    } slot_t;

    typedef struct packed {
        state_t st;
        state_t after;
        msg_t msg;
        logic [`LEN_W-1:0] len;
        logic [`LEN_W-1:0] idx;
        logic [`CONN_W-1:0] conn;
        logic from_net;
        logic expect_reply;
        logic [23:0] tmo;
        logic wait_reply;
        logic [`CONN_W-1:0] wait_conn;
        logic [7:0] wait_local;
        slot_t [`Q_SLOTS-1:0] slots;
        logic [`Q_PTR_W-1:0] q_rd;
        logic [`Q_PTR_W-1:0] q_wr;
        logic [`Q_PTR_W:0] q_cnt;
        slot_t rx;
        logic rx_busy;
        logic rx_keep;
        logic [31:0] ctrl;
        logic [31:0] permit_lo;
        logic [31:0] permit_hi;
        logic [`MAP_ENTRIES-1:0][31:0] map;
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [31:0] r_d;
        logic [1:0] r_r;
        logic [23:0] blink;
        logic [7:0] led;
    } regs_t;
endpackage : bridge_pkg
`default_nettype wire

// [verilog/ethernet_serial_message_bridge.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "bridge_map.svh"

module ethernet_serial_message_bridge #(
    parameter int unsigned RUN_FAST_HALF = `CLK_HZ / 1000 * `RUN_FAST_HALF_MS, // Fast blink half period, cycles
    parameter int unsigned RUN_SLOW_HALF = `CLK_HZ / 1000 * `RUN_SLOW_HALF_MS, // Slow blink half period, cycles
    parameter int unsigned REPLY_WAIT = `CLK_HZ / 1000 * `REPLY_WAIT_MS // Station reply timeout, cycles
) (
    input wire logic aclk, // 20 MHz clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] awaddr, // AXI write address
    input wire logic awvalid, // AXI write address valid
    output logic awready, // AXI write address ready
    input wire logic [31:0] wdata, // AXI write data
    input wire logic [3:0] wstrb, // AXI write strobes
    input wire logic wvalid, // AXI write data valid
    output logic wready, // AXI write data ready
    output logic [1:0] bresp, // AXI write response
    output logic bvalid, // AXI write response valid
    input wire logic bready, // AXI write response ready
    input wire logic [7:0] araddr, // AXI read address
    input wire logic arvalid, // AXI read address valid
    output logic arready, // AXI read address ready
    output logic [31:0] rdata, // AXI read data
    output logic [1:0] rresp, // AXI read response
    output logic rvalid, // AXI read data valid
    input wire logic rready, // AXI read data ready
    input wire logic net_link, // Network link up level
    input wire logic [7:0] net_rx_data, // Network packet byte in
    input wire logic net_rx_valid, // Network byte valid
    input wire logic net_rx_last, // Last byte of packet
    input wire logic [`CONN_W-1:0] net_rx_conn, // Source connection of packet
    input wire logic [31:0] net_rx_ip, // Source host address
    output logic net_rx_ready, // Queue has room
    output logic [7:0] net_tx_data, // Network packet byte out
    output logic net_tx_valid, // Network byte valid
    output logic net_tx_last, // Last byte of packet
    output logic [`CONN_W-1:0] net_tx_conn, // Destination connection
    input wire logic net_tx_ready, // Network side takes byte
    input wire logic [7:0] ser_rx_data, // Bridge serial byte in
    input wire logic ser_rx_valid, // Serial byte valid
    input wire logic ser_rx_last, // Last byte of message
    output logic ser_rx_ready, // Bridge takes serial byte
    output logic [7:0] ser_tx_data, // Bridge serial byte out
    output logic ser_tx_valid, // Serial byte valid
    output logic ser_tx_last, // Last byte of message
    input wire logic ser_tx_ready, // Serial transmitter takes byte
    input wire logic aux_rx_busy, // Auxiliary port receiving
    input wire logic aux_tx_busy, // Auxiliary port sending
    output logic led_link, // Network link indicator
    output logic led_net_rx, // Network receive indicator
    output logic led_net_tx, // Network transmit indicator
    output logic led_ser_rx, // Bridge serial receive indicator
    output logic led_ser_tx, // Bridge serial transmit indicator
    output logic led_aux_rx, // Auxiliary serial receive indicator
    output logic led_aux_tx, // Auxiliary serial transmit indicator
    output logic led_run // Module status indicator
);

    // ----------------------------------------------------------------
    // State and constants
    // ----------------------------------------------------------------
    localparam logic [23:0] FAST_LIM = 24'(RUN_FAST_HALF - 1), SLOW_LIM = 24'(RUN_SLOW_HALF - 1),
        WAIT_LIM = 24'(REPLY_WAIT - 1);
    localparam int LED_LINK = 0, LED_NRX = 1, LED_NTX = 2, LED_SRX = 3;
    localparam int LED_STX = 4, LED_ARX = 5, LED_ATX = 6, LED_RUN = 7;

    bridge_pkg::regs_t q, d;
    logic [15:0] vreg [`VREG_WORDS];
    logic vreg_we;
    logic [`VREG_AW-1:0] vreg_addr;
    logic [15:0] vreg_wdata, vreg_rdata;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte sum of all bytes before the last, placed in the last byte
    function automatic bridge_pkg::msg_t with_cks(bridge_pkg::msg_t m, logic [`LEN_W-1:0] n);
        logic [7:0] s;
        bridge_pkg::msg_t r;
        s = 8'h00;
        r = m;
        for (int i = 0; i < `MSG_BYTES; i++) begin
            if (`LEN_W'(i) + `LEN_W'(1) < n) begin
                s = s + m[i];
            end
        end
        if (n != '0) begin
            r[5'(n - `LEN_W'(1))] = s;
        end
        return r;
    endfunction : with_cks

    // Byte-lane merge for AXI write strobes
    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (old & ~m) | (nw & m);
    endfunction : merge

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic client, virt, permit, first_keep, keep, push, pop, hit, vok;
        logic [`MAP_IDX_W-1:0] hidx, mi;
        logic [`LEN_W-1:0] ridx, nlen;
        logic [15:0] vaddr;
        logic [7:0] wa, ra;
        bridge_pkg::slot_t head;
        d = q;
        client = q.ctrl[`CTRL_CLIENT];
        virt = q.ctrl[`CTRL_VIRT];
        push = 1'b0;
        pop = 1'b0;
        hit = 1'b0;
        hidx = '0;
        mi = '0;
        nlen = '0;
        vaddr = '0;
        vok = 1'b0;
        vreg_we = 1'b0;
        vreg_addr = '0;
        vreg_wdata = '0;
        head = q.slots[q.q_rd];
        // AXI write channel: address and data taken in either order
        d.b_v = q.b_v && !bready;
        if (awvalid && !q.aw_v && !q.b_v) begin
            d.aw_v = 1'b1;
            d.aw_a = awaddr;
        end
        if (wvalid && !q.w_v && !q.b_v) begin
            d.w_v = 1'b1;
            d.w_d = wdata;
            d.w_s = wstrb;
        end
        wa = {d.aw_a[7:2], 2'b00};
        mi = `MAP_IDX_W'((wa - `REG_MAP_BASE) >> 2);
        if (d.aw_v && d.w_v && !q.b_v) begin
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.b_v = 1'b1;
            d.b_r = `RESP_OKAY;
            if (wa == `REG_CTRL) begin
                d.ctrl = merge(q.ctrl, d.w_d, d.w_s) & `CTRL_MASK;
            end else if (wa == `REG_PERMIT_LO) begin
                d.permit_lo = merge(q.permit_lo, d.w_d, d.w_s);
            end else if (wa == `REG_PERMIT_HI) begin
                d.permit_hi = merge(q.permit_hi, d.w_d, d.w_s);
            end else if (wa >= `REG_MAP_BASE && wa < `REG_MAP_END) begin
                d.map[mi] = merge(q.map[mi], d.w_d, d.w_s);
            end else if (wa != `REG_STATUS) begin
                d.b_r = `RESP_SLVERR;
            end
        end
        // AXI read channel, answered one cycle after the address
        d.r_v = q.r_v && !rready;
        ra = {araddr[7:2], 2'b00};
        if (arvalid && !q.r_v) begin
            d.r_v = 1'b1;
            d.r_r = `RESP_OKAY;
            d.r_d = '0;
            mi = `MAP_IDX_W'((ra - `REG_MAP_BASE) >> 2);
            if (ra == `REG_CTRL) begin
                d.r_d = q.ctrl;
            end else if (ra == `REG_STATUS) begin
                d.r_d = {21'h0, q.q_cnt, q.wait_reply, q.led[LED_LINK], q.from_net, q.st};
            end else if (ra == `REG_PERMIT_LO) begin
                d.r_d = q.permit_lo;
            end else if (ra == `REG_PERMIT_HI) begin
                d.r_d = q.permit_hi;
            end else if (ra >= `REG_MAP_BASE && ra < `REG_MAP_END) begin
                d.r_d = q.map[mi];
            end else begin
                d.r_r = `RESP_SLVERR;
            end
        end
        // Network receive: filter on first byte, then queue packet, keeping at most its first 32 bytes
        permit = (net_rx_ip >= q.permit_lo) && (net_rx_ip <= q.permit_hi);
        first_keep = permit && (!client
            || (q.wait_reply && net_rx_conn == q.wait_conn)
            || (virt && net_rx_data == `VIRT_STATION));
        ridx = q.rx_busy ? q.rx.len : '0;
        keep = q.rx_busy ? q.rx_keep : first_keep;
        if (net_rx_valid && net_rx_ready) begin
            if (!q.rx_busy) begin
                d.rx.conn = net_rx_conn;
            end
            if (ridx != `MSG_FULL) begin
                d.rx.msg[5'(ridx)] = net_rx_data;
                d.rx.len = ridx + `LEN_W'(1);
            end
            d.rx_keep = keep;
            d.rx_busy = !net_rx_last;
            if (net_rx_last && keep) begin
                push = 1'b1;
            end
        end
        // Message engine
        unique case (q.st)
            bridge_pkg::S_IDLE: begin
                d.idx = '0;
                d.tmo = '0;
                if (q.q_cnt != '0) begin
                    pop = 1'b1;
                    d.msg = head.msg;
                    d.len = head.len;
                    d.conn = head.conn;
                    d.from_net = 1'b1;
                    d.after = bridge_pkg::S_IDLE;
                    if (virt && head.msg[0] == `VIRT_STATION) begin
                        d.st = bridge_pkg::S_VIRT;
                    end else if (client) begin
                        d.msg[0] = q.wait_local;
                        d.msg = with_cks(d.msg, head.len);
                        d.wait_reply = 1'b0;
                        d.st = bridge_pkg::S_SER_TX;
                    end else begin
                        d.after = bridge_pkg::S_SER_RX;
                        d.st = bridge_pkg::S_SER_TX;
                    end
                end else if (ser_rx_valid) begin
                    d.from_net = 1'b0;
                    d.expect_reply = 1'b0;
                    d.st = bridge_pkg::S_SER_RX;
                end
            end
            bridge_pkg::S_SER_RX: begin
                if (ser_rx_valid) begin
                    nlen = (q.idx == `MSG_FULL) ? q.idx : q.idx + `LEN_W'(1);
                    if (q.idx != `MSG_FULL) begin
                        d.msg[5'(q.idx)] = ser_rx_data;
                    end
                    d.idx = nlen;
                    for (int i = 0; i < `MAP_ENTRIES; i++) begin
                        if (!hit && q.map[i][`MAP_VALID] && q.map[i][`MAP_LOCAL_LSB +: 8] == d.msg[0]) begin
                            hit = 1'b1;
                            hidx = `MAP_IDX_W'(i);
                        end
                    end
                    if (ser_rx_last) begin
                        d.len = nlen;
                        d.idx = '0;
                        if (!client) begin
                            d.st = q.expect_reply ? bridge_pkg::S_NET_TX : bridge_pkg::S_IDLE;
                        end else if (virt && d.msg[0] == `VIRT_STATION) begin
                            d.st = bridge_pkg::S_VIRT;
                        end else if (hit) begin
                            d.wait_local = d.msg[0];
                            d.msg[0] = q.map[hidx][`MAP_REMOTE_LSB +: 8];
                            d.msg = with_cks(d.msg, nlen);
                            d.conn = q.map[hidx][`MAP_CONN_LSB +: `CONN_W];
                            d.wait_conn = d.conn;
                            d.wait_reply = 1'b1;
                            d.st = bridge_pkg::S_NET_TX;
                        end else begin
                            d.st = bridge_pkg::S_IDLE;
                        end
                    end
                end else if (q.expect_reply && q.idx == '0) begin
                    // A silent station must not block the queue for ever
                    d.tmo = q.tmo + 24'h1;
                    if (q.tmo >= WAIT_LIM) begin
                        d.st = bridge_pkg::S_IDLE;
                    end
                end
            end
            bridge_pkg::S_SER_TX: begin
                if (ser_tx_ready) begin
                    d.msg = q.msg >> 8;
                    d.idx = q.idx + `LEN_W'(1);
                    if (ser_tx_last) begin
                        d.idx = '0;
                        d.tmo = '0;
                        d.expect_reply = (q.after == bridge_pkg::S_SER_RX);
                        d.st = q.after;
                    end
                end
            end
            bridge_pkg::S_NET_TX: begin
                if (net_tx_ready) begin
                    d.msg = q.msg >> 8;
                    d.idx = q.idx + `LEN_W'(1);
                    if (net_tx_last) begin
                        d.idx = '0;
                        d.st = bridge_pkg::S_IDLE;
                    end
                end
            end
            bridge_pkg::S_VIRT: begin
                vaddr = {q.msg[2], q.msg[3]};
                vok = (q.len == `VIRT_CMD_LEN) && (vaddr < `VREG_WORDS)
                    && (q.msg[1] == `OP_READ || q.msg[1] == `OP_WRITE);
                vreg_addr = vok ? vaddr[`VREG_AW-1:0] : '0;
                vreg_wdata = {q.msg[4], q.msg[5]};
                vreg_we = vok && q.msg[1] == `OP_WRITE;
                d.msg = '0;
                d.msg[0] = `VIRT_STATION;
                d.msg[1] = q.msg[1];
                d.msg[2] = vok ? `ST_OK : `ST_BAD;
                d.msg[3] = vreg_we ? q.msg[4] : vreg_rdata[15:8];
                d.msg[4] = vreg_we ? q.msg[5] : vreg_rdata[7:0];
                d.len = `VIRT_REPLY_LEN;
                d.msg = with_cks(d.msg, `VIRT_REPLY_LEN);
                d.idx = '0;
                d.after = bridge_pkg::S_IDLE;
                d.st = q.from_net ? bridge_pkg::S_NET_TX : bridge_pkg::S_SER_TX;
            end
        endcase
        // Queue pointers; push and pop may share a cycle
        if (push) begin
            d.slots[q.q_wr] = d.rx;
            d.q_wr = q.q_wr + `Q_PTR_W'(1);
        end
        if (pop) begin
            d.q_rd = q.q_rd + `Q_PTR_W'(1);
        end
        d.q_cnt = q.q_cnt + (push ? (`Q_PTR_W+1)'(1) : '0) - (pop ? (`Q_PTR_W+1)'(1) : '0);
        // Indicators, registered to keep the lamps glitch free
        d.led[LED_LINK] = net_link;
        d.led[LED_NRX] = net_rx_valid || q.rx_busy;
        d.led[LED_NTX] = q.st == bridge_pkg::S_NET_TX;
        d.led[LED_SRX] = ser_rx_valid || (q.st == bridge_pkg::S_SER_RX && q.idx != '0);
        d.led[LED_STX] = q.st == bridge_pkg::S_SER_TX;
        d.led[LED_ARX] = aux_rx_busy;
        d.led[LED_ATX] = aux_tx_busy;
        d.blink = q.blink + 24'h1;
        if (q.blink >= (q.ctrl[`CTRL_SETUP] ? SLOW_LIM : FAST_LIM)) begin
            d.blink = '0;
            d.led[LED_RUN] = !q.led[LED_RUN];
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Whole state in one register; reset clears all but a few fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.st <= bridge_pkg::S_IDLE;
            q.after <= bridge_pkg::S_IDLE;
            q.permit_hi <= `PERMIT_HI_RST;
        end else begin
            q <= d;
        end
    end

    // Virtual station store; not reset, contents undefined at power-up
    always_ff @(posedge aclk) begin
        if (vreg_we) begin
            vreg[vreg_addr] <= vreg_wdata;
        end
    end

    assign vreg_rdata = vreg[vreg_addr];

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Bus handshakes
    assign awready = !q.aw_v && !q.b_v;
    assign wready = !q.w_v && !q.b_v;
    assign bvalid = q.b_v;
    assign bresp = q.b_r;
    assign arready = !q.r_v;
    assign rvalid = q.r_v;
    assign rdata = q.r_d;
    assign rresp = q.r_r;
    // Streams: byte 0 of the shifting buffer is always the next byte
    assign net_rx_ready = q.q_cnt != `Q_FULL;
    assign net_tx_valid = q.st == bridge_pkg::S_NET_TX;
    assign net_tx_data = q.msg[0];
    assign net_tx_last = q.idx == q.len - `LEN_W'(1);
    assign net_tx_conn = q.conn;
    assign ser_rx_ready = q.st == bridge_pkg::S_SER_RX;
    assign ser_tx_valid = q.st == bridge_pkg::S_SER_TX;
    assign ser_tx_data = q.msg[0];
    assign ser_tx_last = q.idx == q.len - `LEN_W'(1);
    // Lamps
    assign led_link = q.led[LED_LINK];
    assign led_net_rx = q.led[LED_NRX];
    assign led_net_tx = q.led[LED_NTX];
    assign led_ser_rx = q.led[LED_SRX];
    assign led_ser_tx = q.led[LED_STX];
    assign led_aux_rx = q.led[LED_ARX];
    assign led_aux_tx = q.led[LED_ATX];
    assign led_run = q.led[LED_RUN];

endmodule : ethernet_serial_message_bridge
`default_nettype wire

// [test/bridge_station.sv]
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------
// Station on the serial line
// ---------------------------------
module bridge_station #(
    parameter logic [7:0] STATION = 8'h05 // Own number
) (
    input wire logic clk, // Clock
    input wire logic go, // Send command
    input wire logic [7:0] dst, // Command target
    input wire logic [7:0] tx_data, // Byte in
    input wire logic tx_valid, // Byte valid
    input wire logic tx_last, // Last byte
    output logic tx_ready, // Takes byte
    output logic [7:0] rx_data, // Byte out
    output logic rx_valid, // Byte valid
    output logic rx_last, // Last byte
    input wire logic rx_ready // Byte taken
);
    logic [23:0] sh = '0;
    logic [23:0] msg = '0;
    int k = 0;
    // Idle line shows no stale byte
    assign tx_ready = 1'b1;
    assign rx_valid = k > 0;
    assign rx_last = k == 1;
    assign rx_data = k > 0 ? msg[8*k-1-:8] : ~msg[7:0];
    // Echo frames for own number; send on go
    always @(posedge clk) begin
        if (tx_valid) sh <= {sh[15:0], tx_data};
        if (rx_valid && rx_ready) k <= k - 1;
        if (tx_valid && tx_last && sh[15:8] == STATION) begin
            msg <= {sh[15:0], tx_data};
            k <= 3;
        end else if (go) begin
            msg <= {dst, 8'h41, dst + 8'h41};
            k <= 3;
        end
    end
endmodule : bridge_station
`default_nettype wire

// [test/ethernet_serial_message_bridge_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module bridge_assertions (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic net_link, // Link in
    input wire logic led_link, // Link lamp
    input wire logic aux_rx_busy, // Aux busy
    input wire logic led_aux_rx, // Aux lamp
    input wire logic bvalid, // B valid
    input wire logic bready, // B ready
    input wire logic awready, // AW ready
    input wire logic wready, // W ready
    input wire logic rvalid, // R valid
    input wire logic rready, // R ready
    input wire logic arready // AR ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_lit; net_link |=> led_link; endproperty
    a_lit: assert property (p_lit) else $error("link dark");
    property p_dark; !net_link |=> !led_link; endproperty
    a_dark: assert property (p_dark) else $error("link lit");
    property p_aux; aux_rx_busy |=> led_aux_rx; endproperty
    a_aux: assert property (p_aux) else $error("aux dark");
    property p_bhold; bvalid && !bready |=> bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("b dropped");
    property p_rhold; rvalid && !rready |=> rvalid && $stable(rvalid); endproperty
    a_rhold: assert property (p_rhold) else $error("r dropped");
    property p_aw; bvalid |-> !awready; endproperty
    a_aw: assert property (p_aw) else $error("aw open");
    property p_w; bvalid |-> !wready; endproperty
    a_w: assert property (p_w) else $error("w open");
    property p_ar; rvalid |-> !arready; endproperty
    a_ar: assert property (p_ar) else $error("ar open");
endmodule : bridge_assertions
bind ethernet_serial_message_bridge bridge_assertions chk_u (.*);
`default_nettype wire

// [test/test_ethernet_serial_message_bridge.sv]
`timescale 1ns/100ps
`default_nettype none
module test_ethernet_serial_message_bridge;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0;
    logic net_link = 0, net_rx_valid = 0, net_rx_last = 0, aux_rx_busy = 0, aux_tx_busy = 0;
    logic net_tx_ready = 1, ser_rx_valid, ser_rx_last, ser_tx_ready, awready, wready, bvalid, arready;
    logic [7:0] awaddr = 0, araddr = 0, net_rx_data = 0, dst = 0, ser_rx_data, ser_tx_data, net_tx_data;
    logic [31:0] wdata = 0, net_rx_ip = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [2:0] net_rx_conn = 0, net_tx_conn, n_c;
    logic [1:0] bresp, rresp;
    logic rvalid, net_rx_ready, net_tx_valid, net_tx_last, ser_rx_ready, ser_tx_valid, ser_tx_last;
    logic led_link, led_net_rx, led_net_tx, led_ser_rx, led_ser_tx, led_aux_rx, led_aux_tx, led_run;
    logic [23:0] s_sh, n_sh;
    int s_n = 0, n_n = 0, num_errors = 0, n_compared = 0;
    always #25 aclk = ~aclk;
    ethernet_serial_message_bridge #(.RUN_FAST_HALF(8), .RUN_SLOW_HALF(16), .REPLY_WAIT(64)) dut_u (.*);
    bridge_station st_u (.clk(aclk), .go(go), .dst(dst), .tx_data(ser_tx_data), .tx_valid(ser_tx_valid),
        .tx_last(ser_tx_last), .tx_ready(ser_tx_ready), .rx_data(ser_rx_data), .rx_valid(ser_rx_valid),
        .rx_last(ser_rx_last), .rx_ready(ser_rx_ready));
    // Last three bytes and counts of both outgoing streams
    always @(posedge aclk) begin
        if (ser_tx_valid && ser_tx_ready) begin s_sh <= {s_sh[15:0], ser_tx_data}; s_n <= s_n + 1; end
        if (net_tx_valid && net_tx_ready) begin n_sh <= {n_sh[15:0], net_tx_data}; n_n <= n_n + 1; n_c <= net_tx_conn; end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end
    endtask : chk
    task automatic upto(ref int c, input int t);
        for (int k = 0; k < 600 && c < t; k++) @(posedge aclk);
    endtask : upto
    // Caller drops net_rx_valid after the last packet
    task automatic nsend(input logic [23:0] m, input logic [2:0] c);
        for (int i = 2; i >= 0; i--) begin
            net_rx_data <= m[8*i+:8]; net_rx_valid <= 1; net_rx_last <= i == 0; net_rx_conn <= c;
            do @(posedge aclk); while (net_rx_ready !== 1);
        end
    endtask : nsend
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk); if (awready) awvalid <= 0; if (wready) wvalid <= 0;
        end while (awvalid && !awready || wvalid && !wready);
        do @(posedge aclk); while (bvalid !== 1);
        bready <= 0; chk("bresp", 0, bresp); @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1);
        rready <= 0; chk("rdata", e, rdata); chk("rresp", r, rresp); @(posedge aclk);
    endtask : rd
    task automatic t_regs;
        rd(8'h00, 0, 2'b00); rd(8'h0c, 32'hffff_ffff, 2'b00); rd(8'h20, 0, 2'b10);
    endtask : t_regs
    task automatic t_server;
        nsend(24'h09414a, 1); nsend(24'h054146, 2); nsend(24'h054247, 3); net_rx_valid <= 0;
        upto(n_n, 1); chk("fwd count", 6, s_n);
        upto(n_n, 3); chk("reply", 32'h054146, n_sh); chk("conn", 2, n_c);
        upto(n_n, 6); chk("reply2", 32'h054247, n_sh); chk("fwd", 32'h054247, s_sh);
    endtask : t_server
    task automatic t_client;
        wr(8'h40, 32'h8001_0507); wr(8'h00, 32'h0000_0001);
        dst <= 8'h06; go <= 1; @(posedge aclk); go <= 0; repeat (60) @(posedge aclk);
        chk("unmapped", 6, n_n);
        dst <= 8'h07; go <= 1; @(posedge aclk); go <= 0;
        upto(n_n, 9); chk("mapped", 32'h054146, n_sh); chk("conn", 1, n_c);
        nsend(24'h054044, 5); nsend(24'h054146, 1); net_rx_valid <= 0;
        upto(s_n, 12); chk("back", 32'h074148, s_sh);
        repeat (60) @(posedge aclk); chk("blocked", 12, s_n);
    endtask : t_client
    task automatic close_out;
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // Main sequence, then watchdog
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1; net_link <= 1; aux_rx_busy <= 1; @(posedge aclk);
        t_regs; t_server; net_link <= 0; aux_rx_busy <= 0; t_client; close_out;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++; close_out;
    end
endmodule : test_ethernet_serial_message_bridge
`default_nettype wire
